// File: rtl/motion_pkg.sv
// Constants for the serial microstep position control block.
// Assumes a 16-bit frame on a four-wire serial link, MSB first.
package motion_pkg;
	localparam int FRAME_BITS = 16;
	localparam int ADDR_MSB   = 15;
	localparam int ADDR_LSB   = 14;
	localparam int DATA_W     = 14;
	localparam int IDX_W      = 6;
	localparam int ENTRY_W    = 6;
	localparam int TBL_LOAD_N = 16;
	localparam int SC_LSB     = 0;
	localparam int RUN_CFG_LSB = 6;
	localparam int RUN_CFG_W  = 8;
	localparam int CNT_W      = 5;

	localparam logic [1:0] ADDR_CFG0 = 2'h0;
	localparam logic [1:0] ADDR_CFG1 = 2'h1;
	localparam logic [1:0] ADDR_TBL  = 2'h2;
	localparam logic [1:0] ADDR_RUN  = 2'h3;

	localparam logic [IDX_W-1:0]     INDEX_RST   = 6'h00;
	localparam logic [IDX_W-1:0]     IDX_QUARTER = 6'h10;
	localparam logic [IDX_W-1:0]     IDX_HALF    = 6'h20;
	localparam logic [IDX_W-1:0]     IDX_3QUART  = 6'h30;
	localparam logic [3:0]           PTR_RST     = 4'h0;
	localparam logic [3:0]           PTR_LAST    = 4'hf;
	localparam logic [DATA_W-1:0]    CFG_RST     = 14'h0000;
	localparam logic [RUN_CFG_W-1:0] RUN_CFG_RST = 8'h00;
	localparam logic [2:0]           PIN_IDLE    = 3'h4;
	localparam logic [CNT_W-1:0]     CNT_RST     = 5'h00;
	localparam logic [CNT_W-1:0]     CNT_OVER    = 5'h11;

	// Entry 0 is fixed at zero; entries 1 to 16 form a quarter sine.
	localparam logic [17*ENTRY_W-1:0] DEFAULT_TABLE = {
		6'h3f, 6'h3f, 6'h3e, 6'h3c, 6'h3a, 6'h37, 6'h34, 6'h30, 6'h2c,
		6'h28, 6'h23, 6'h1d, 6'h17, 6'h12, 6'h0b, 6'h05, 6'h00};
	localparam logic [TBL_LOAD_N*ENTRY_W-1:0] TBL_RST = '0;
endpackage : motion_pkg

// File: rtl/phase_current_lookup.sv
// Folds a step angle index onto the 17-entry quarter table.
// Assumes entry 0 of the table is zero and the sign is handled outside.
`timescale 1ns/100ps
module phase_current_lookup
	import motion_pkg::*;
(
	input  wire logic [IDX_W-1:0]      idx,
	input  wire logic [17*ENTRY_W-1:0] table_flat,
	output logic      [ENTRY_W-1:0]    magnitude
);
	logic [4:0] sel;

	// Odd quadrants run the table backwards
	always_comb begin
		if (idx[4]) begin
			sel = 5'(5'h10 - {1'b0, idx[3:0]});
		end else begin
			sel = {1'b0, idx[3:0]};
		end
		magnitude = table_flat[sel*ENTRY_W +: ENTRY_W];
	end
endmodule : phase_current_lookup

// File: rtl/serial_microstep_position_control.sv
// Serial microstep position control: four-wire link, step index, tables.
// Assumes pins are asynchronous to clk_sys and sck is well below clk_sys/4.
`timescale 1ns/100ps
module serial_microstep_position_control
	import motion_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst_b,
	input  wire logic                 ce,
	input  wire logic                 serial_strobe_low,
	input  wire logic                 sck,
	input  wire logic                 sdi,
	output logic                      sdo,
	output logic                      sdo_oe,
	output logic      [IDX_W-1:0]     step_index,
	output logic      [ENTRY_W-1:0]   phase_a_mag,
	output logic                      phase_a_rev,
	output logic      [ENTRY_W-1:0]   phase_b_mag,
	output logic                      phase_b_rev,
	output logic      [RUN_CFG_W-1:0] run_cfg,
	output logic      [DATA_W-1:0]    cfg0,
	output logic      [DATA_W-1:0]    cfg1,
	output logic                      table_custom,
	output logic                      step_done
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// Pin synchronisers: {strobe, sck, sdi}
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic [2:0] prev_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			// Idle pin levels, so no false strobe or clock edge after reset
			meta_q <= PIN_IDLE;
			sync_q <= PIN_IDLE;
			prev_q <= PIN_IDLE;
		end else if (ce) begin
			meta_q <= {serial_strobe_low, sck, sdi};
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	logic strb_fall;
	logic strb_rise;
	logic sck_rise;
	logic sck_fall;
	logic in_frame;

	assign strb_fall = prev_q[2] & ~sync_q[2];
	assign strb_rise = ~prev_q[2] & sync_q[2];
	assign sck_rise  = ~prev_q[1] & sync_q[1];
	assign sck_fall  = prev_q[1] & ~sync_q[1];
	assign in_frame  = ~sync_q[2];

	// Serial shifter
	logic [FRAME_BITS-1:0] shift_q, shift_d;
	logic [FRAME_BITS-1:0] out_q, out_d;
	logic [CNT_W-1:0]      cnt_q, cnt_d;
	logic                  sdo_q, sdo_d;
	logic [FRAME_BITS-1:0] status_word;
	logic [IDX_W-1:0]      index_q, index_d;
	logic [3:0]            ptr_q, ptr_d;
	logic                  custom_q, custom_d;

	assign status_word = {custom_q, 3'h0, ptr_q, 2'h0, index_q};

	always_comb begin
		shift_d = shift_q;
		out_d   = out_q;
		cnt_d   = cnt_q;
		sdo_d   = sdo_q;
		if (strb_fall) begin
			cnt_d = CNT_RST;
			out_d = status_word;
			sdo_d = status_word[FRAME_BITS-1];
		end else if (in_frame && sck_rise) begin
			shift_d = {shift_q[FRAME_BITS-2:0], sync_q[0]};
			// Saturate so long frames are still seen as wrong length
			if (cnt_q != CNT_OVER) begin
				cnt_d = 5'(cnt_q + 5'h01);
			end
		end else if (in_frame && sck_fall) begin
			out_d = {out_q[FRAME_BITS-2:0], 1'b0};
			sdo_d = out_q[FRAME_BITS-2];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			shift_q <= '0;
			out_q   <= '0;
			cnt_q   <= CNT_RST;
			sdo_q   <= 1'b0;
		end else if (ce) begin
			shift_q <= shift_d;
			out_q   <= out_d;
			cnt_q   <= cnt_d;
			sdo_q   <= sdo_d;
		end
	end

	assign sdo    = sdo_q;
	// Follows the synced strobe, so it spans every host sample point
	assign sdo_oe = in_frame;

	// Frame decode; only whole frames act, on the strobe rise
	logic                 commit;
	logic [1:0]           addr;
	logic [DATA_W-1:0]    data;
	logic [IDX_W-1:0]     sc;
	logic [RUN_CFG_W-1:0] run_cfg_in;
	logic [IDX_W-1:0]     run_sum;
	logic                 run_commit;
	logic                 tbl_commit;

	assign commit     = strb_rise && (cnt_q == CNT_W'(FRAME_BITS));
	assign addr       = shift_q[ADDR_MSB:ADDR_LSB];
	assign data       = shift_q[DATA_W-1:0];
	assign sc         = data[SC_LSB +: IDX_W];
	assign run_cfg_in = data[RUN_CFG_LSB +: RUN_CFG_W];
	// Six-bit add wraps by itself, signed or not
	assign run_sum    = index_q + sc;
	assign run_commit = commit && (addr == ADDR_RUN);
	assign tbl_commit = commit && (addr == ADDR_TBL);

	// Control state
	logic [RUN_CFG_W-1:0]          run_cfg_q, run_cfg_d;
	logic [DATA_W-1:0]             cfg0_q, cfg0_d;
	logic [DATA_W-1:0]             cfg1_q, cfg1_d;
	logic [TBL_LOAD_N*ENTRY_W-1:0] tbl_q, tbl_d;
	logic                          done_q, done_d;

	always_comb begin
		index_d   = index_q;
		run_cfg_d = run_cfg_q;
		cfg0_d    = cfg0_q;
		cfg1_d    = cfg1_q;
		tbl_d     = tbl_q;
		ptr_d     = ptr_q;
		custom_d  = custom_q;
		done_d    = 1'b0;
		if (run_commit) begin
			index_d   = run_sum;
			run_cfg_d = run_cfg_in;
			done_d    = 1'b1;
		end else if (tbl_commit) begin
			tbl_d[ptr_q*ENTRY_W +: ENTRY_W] = data[ENTRY_W-1:0];
			ptr_d = 4'(ptr_q + 4'h1);
			// Partial loads keep the sine profile until all 16 arrive
			if (ptr_q == PTR_LAST) begin
				custom_d = 1'b1;
			end
		end else if (commit && (addr == ADDR_CFG0)) begin
			cfg0_d = data;
		end else if (commit && (addr == ADDR_CFG1)) begin
			cfg1_d = data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			index_q   <= INDEX_RST;
			run_cfg_q <= RUN_CFG_RST;
			cfg0_q    <= CFG_RST;
			cfg1_q    <= CFG_RST;
			tbl_q     <= TBL_RST;
			ptr_q     <= PTR_RST;
			custom_q  <= 1'b0;
			done_q    <= 1'b0;
		end else if (ce) begin
			index_q   <= index_d;
			run_cfg_q <= run_cfg_d;
			cfg0_q    <= cfg0_d;
			cfg1_q    <= cfg1_d;
			tbl_q     <= tbl_d;
			ptr_q     <= ptr_d;
			custom_q  <= custom_d;
			done_q    <= done_d;
		end
	end

	assign step_index   = index_q;
	assign run_cfg      = run_cfg_q;
	assign cfg0         = cfg0_q;
	assign cfg1         = cfg1_q;
	assign table_custom = custom_q;
	assign step_done    = done_q;

	// Phase current lookup; phase B leads phase A by a quarter cycle
	logic [17*ENTRY_W-1:0] table_flat;
	logic [IDX_W-1:0]      idx_b;
	logic [ENTRY_W-1:0]    mag_a;
	logic [ENTRY_W-1:0]    mag_b;
	logic [ENTRY_W-1:0]    mag_a_q, mag_a_d;
	logic [ENTRY_W-1:0]    mag_b_q, mag_b_d;
	logic                  rev_a_q, rev_a_d;
	logic                  rev_b_q, rev_b_d;

	assign table_flat = custom_q ? {tbl_q, {ENTRY_W{1'b0}}}
		: DEFAULT_TABLE;
	assign idx_b = index_q + IDX_QUARTER;

	phase_current_lookup u_lookup_a (
		.idx        (index_q),
		.table_flat (table_flat),
		.magnitude  (mag_a)
	);

	phase_current_lookup u_lookup_b (
		.idx        (idx_b),
		.table_flat (table_flat),
		.magnitude  (mag_b)
	);

	always_comb begin
		mag_a_d = mag_a;
		mag_b_d = mag_b;
		rev_a_d = index_q > IDX_HALF;
		rev_b_d = (index_q > IDX_QUARTER) && (index_q <= IDX_3QUART);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mag_a_q <= '0;
			mag_b_q <= '0;
			rev_a_q <= 1'b0;
			rev_b_q <= 1'b0;
		end else if (ce) begin
			mag_a_q <= mag_a_d;
			mag_b_q <= mag_b_d;
			rev_a_q <= rev_a_d;
			rev_b_q <= rev_b_d;
		end
	end

	assign phase_a_mag = mag_a_q;
	assign phase_b_mag = mag_b_q;
	assign phase_a_rev = rev_a_q;
	assign phase_b_rev = rev_b_q;

	// Checks
	index_wrap_a: assert property (
		ce && run_commit |=> index_q == $past(run_sum) && step_done)
		else $error("index did not take index plus step change");

	index_hold_a: assert property (
		ce && !run_commit |=> $stable(index_q))
		else $error("index moved without a motion write");

	strobe_edge_a: assert property (
		$rose(step_done) |-> $past(strb_rise))
		else $error("step applied away from strobe rise");

	zero_step_a: assert property (
		ce && run_commit && sc == '0 |=> $stable(index_q)
			&& run_cfg == $past(run_cfg_in))
		else $error("zero step changed index or lost config");

	frame_len_a: assert property (
		ce && strb_rise && cnt_q != CNT_W'(FRAME_BITS)
			|=> $stable(cfg0_q) && $stable(cfg1_q) && $stable(ptr_q))
		else $error("short or long frame was acted on");

	table_load_a: assert property (
		ce && tbl_commit |=> ptr_q == 4'($past(ptr_q) + 4'h1))
		else $error("table pointer did not advance");

	custom_set_a: assert property (
		ce && tbl_commit && ptr_q == PTR_LAST |=> table_custom)
		else $error("custom table not selected after full load");

	default_prof_a: assert property (
		ce && !custom_q && index_q == IDX_HALF
			|=> phase_a_mag == '0
			&& phase_b_mag == DEFAULT_TABLE[16*ENTRY_W +: ENTRY_W])
		else $error("default profile wrong at half cycle");

	zero_entry_a: assert property (
		ce && index_q == INDEX_RST |=> phase_a_mag == '0)
		else $error("fixed zero entry not zero");

	third_quad_a: assert property (
		ce && index_q > IDX_HALF && index_q < IDX_3QUART
			|=> phase_a_rev && phase_b_rev)
		else $error("third quadrant signs wrong");

	second_quad_a: assert property (
		ce && index_q > IDX_QUARTER && index_q < IDX_HALF
			|=> !phase_a_rev && phase_b_rev)
		else $error("second quadrant signs wrong");

	status_msb_a: assert property (
		ce && strb_fall |=> sdo_oe && sdo == $past(custom_q))
		else $error("status word did not lead on sdo");

	done_pulse_a: assert property (
		ce && step_done |=> !step_done)
		else $error("step done held for more than one cycle");

	custom_keep_a: assert property (
		ce && custom_q && tbl_commit |=> table_custom)
		else $error("custom table dropped on a further load");

	step_fwd_c: cover property (ce && run_commit && sc == 6'h04);
	step_rev_c: cover property (ce && run_commit && sc == 6'h3c);
	wrap_c: cover property (ce && run_commit && index_q == 6'h3f
		&& sc == 6'h01);
	custom_c: cover property ($rose(table_custom));
	refused_c: cover property (ce && strb_rise
		&& cnt_q != CNT_W'(FRAME_BITS));
endmodule : serial_microstep_position_control

// File: testbench/host_link_model.sv
// Host model for the four-wire serial link, one frame per send call.
// Assumes the caller spaces frames; sck stands low between frames.
`timescale 1ns/100ps
module host_link_model (
	output logic      serial_strobe_low,
	output logic      sck,
	output logic      sdi,
	input  wire logic sdo
);
	initial begin
		serial_strobe_low = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end

	// Half period of 16 ns gives the 32 ns link clock
	task automatic send(input logic [15:0] word, input int nbits,
		output logic [15:0] seen);
		seen = 16'h0000;
		serial_strobe_low = 1'b0;
		#16;
		for (int i = 0; i < nbits; i++) begin
			sdi = word[15-i];
			#16 sck = 1'b1;
			seen = {seen[14:0], sdo};
			#16 sck = 1'b0;
		end
		// Line no longer shows the last bit once the frame is over
		sdi = ~sdi;
		#16 serial_strobe_low = 1'b1;
	endtask : send
endmodule : host_link_model

// File: testbench/serial_microstep_position_control_tb.sv
// Self-checking bench for the serial microstep position control block.
// Assumes the host link model drives the pins; expectations kept here.
`timescale 1ns/100ps
module serial_microstep_position_control_tb;
	import motion_pkg::*;
	logic                 clk_sys, rst_b, ce;
	wire logic            strobe_low, sck, sdi, sdo, sdo_oe, sdo_pin;
	logic [IDX_W-1:0]     step_index;
	logic [ENTRY_W-1:0]   phase_a_mag, phase_b_mag;
	logic                 phase_a_rev, phase_b_rev, table_custom, step_done;
	logic [RUN_CFG_W-1:0] run_cfg;
	logic [DATA_W-1:0]    cfg0, cfg1;
	int                   n_fail, checked, seed, pulses, oe_cnt;
	logic [5:0]           idx_exp;
	logic [3:0]           ptr_exp;
	logic                 custom_exp;
	logic [5:0]           ld [17];
	int                   corner [14] =
		'{-1, 1, -2, 2, 0, 4, -4, 16, -16, 8, 2, 16, 6, 4};

	serial_microstep_position_control dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.ce(ce), .serial_strobe_low(strobe_low), .sck(sck), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .step_index(step_index),
		.phase_a_mag(phase_a_mag), .phase_a_rev(phase_a_rev),
		.phase_b_mag(phase_b_mag), .phase_b_rev(phase_b_rev),
		.run_cfg(run_cfg), .cfg0(cfg0), .cfg1(cfg1),
		.table_custom(table_custom), .step_done(step_done));
	host_link_model host (.serial_strobe_low(strobe_low), .sck(sck),
		.sdi(sdi), .sdo(sdo_pin));

	// Released line reads inverted, so a sample outside the window shows
	assign sdo_pin = sdo_oe ? sdo : ~sdo;

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) if (step_done === 1'b1) pulses++;
	always @(posedge clk_sys) if (sdo_oe === 1'b1) oe_cnt++;

	function automatic int fold(input logic [5:0] i);
		return i[4] ? 16 - int'(i[3:0]) : int'(i[3:0]);
	endfunction : fold

	function automatic logic [5:0] ent(input int k);
		return custom_exp ? ld[k] : DEFAULT_TABLE[k*6 +: 6];
	endfunction : ent

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic outputs;
		check("step_index", step_index, idx_exp);
		check("table_custom", table_custom, custom_exp);
		check("sdo_oe", sdo_oe, 1'b0);
		check("phase_a_mag", phase_a_mag, ent(fold(idx_exp)));
		check("phase_b_mag", phase_b_mag, ent(fold(idx_exp + 6'h10)));
		check("phase_a_rev", phase_a_rev, idx_exp > 6'h20);
		check("phase_b_rev", phase_b_rev, idx_exp inside {[17:48]});
	endtask : outputs

	task automatic frame(input logic [1:0] a, input logic [13:0] d,
		input int nb);
		logic [15:0] rd;
		logic        ok;
		int          oe_exp;
		ok = (nb == 16) && ce;
		// Strobe low lasts 32 ns per bit plus 32 ns, both edges synced alike
		oe_exp = ce ? 8 * nb + 8 : 0;
		pulses = 0;
		oe_cnt = 0;
		host.send({a, d}, nb, rd);
		if (ok)
			check("status", rd, {custom_exp, 3'h0, ptr_exp, 2'h0, idx_exp});
		repeat (8) @(negedge clk_sys);
		if (ok && a == ADDR_RUN) begin
			idx_exp = idx_exp + d[5:0];
			check("run_cfg", run_cfg, d[13:6]);
		end
		if (ok && a == ADDR_CFG0) check("cfg0", cfg0, d);
		if (ok && a == ADDR_CFG1) check("cfg1", cfg1, d);
		if (ok && a == ADDR_TBL) begin
			ld[int'(ptr_exp) + 1] = d[5:0];
			custom_exp = custom_exp | (ptr_exp == PTR_LAST);
			ptr_exp = ptr_exp + 4'h1;
		end
		check("step_done", pulses, ok && a == ADDR_RUN);
		check("sdo_oe", oe_cnt, oe_exp);
		outputs();
	endtask : frame

	task automatic run_rand(input int n);
		logic [13:0] w;
		for (int i = 0; i < n; i++) begin
			w = 14'($random(seed));
			w[5:0] = 6'($random(seed) % 17);
			frame(ADDR_RUN, w, 16);
		end
	endtask : run_rand

	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	initial begin
		#200000;
		n_fail++;
		test_done();
	end

	initial begin
		seed = 32'h7a0e;
		rst_b = 1'b0;
		ce = 1'b1;
		n_fail = 0;
		checked = 0;
		idx_exp = INDEX_RST;
		ptr_exp = PTR_RST;
		custom_exp = 1'b0;
		foreach (ld[k]) ld[k] = 6'h00;
		repeat (10) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (3) @(negedge clk_sys);
		check("cfg0", cfg0, CFG_RST);
		check("run_cfg", run_cfg, RUN_CFG_RST);
		outputs();
		$display("test reset done");
		foreach (corner[i])
			frame(ADDR_RUN, {8'($random(seed)), 6'(corner[i])}, 16);
		run_rand(30);
		$display("test run writes done");
		frame(ADDR_CFG0, 14'($random(seed)), 16);
		frame(ADDR_CFG1, 14'($random(seed)), 16);
		frame(ADDR_RUN, 14'h0005, 15);
		frame(ADDR_RUN, 14'h0005, 1);
		@(negedge clk_sys) ce = 1'b0;
		frame(ADDR_RUN, 14'h0005, 16);
		@(negedge clk_sys) ce = 1'b1;
		$display("test config and refused frames done");
		for (int i = 0; i < 16; i++)
			frame(ADDR_TBL, 14'($random(seed)), 16);
		run_rand(6);
		frame(ADDR_TBL, 14'($random(seed)), 16);
		run_rand(2);
		$display("test table load done");
		@(negedge clk_sys) rst_b = 1'b0;
		#1;
		check("step_index", step_index, INDEX_RST);
		check("table_custom", table_custom, 1'b0);
		idx_exp = INDEX_RST;
		ptr_exp = PTR_RST;
		custom_exp = 1'b0;
		repeat (10) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (3) @(negedge clk_sys);
		frame(ADDR_RUN, 14'h0004, 16);
		$display("test second reset done");
		test_done();
	end
endmodule : serial_microstep_position_control_tb
